/* crf_core_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Thirty-two byte registers, single-cycle access.
// - Two operands read, result written same cycle.
// - Four operand and result port combinations.
// - Top six registers form three pointers.
// - Pointers support displacement, increment, decrement.
// - Register n appears at data address n.
// - I/O space at data 0x20 to 0x5F.
// - Extended I/O reachable by load/store only.
// - Status at 0x5F / I/O 0x3F, resets zero.
// - I/O address equals data offset minus 0x20.
// - Bit 7 clear blocks every interrupt.
// - Interrupt entry clears, return sets, ops change.
// - Bit 6 stores and restores one register bit.
// - Bit 5 records low-nibble half carry.
// - Sign flag set to negative xor overflow on each ALU update.
// - Bits 3..0: overflow, negative, zero, carry.
// - Flags update after every ALU operation, except when the status register is written in the same cycle.
// - Next word prefetched while current executes.
// - Instructions are one or two 16-bit words.
// - Interrupt entry or call pushes return counter.
// - Lowest-vector pending interrupt is served first.
module crf_core_regs #(
  parameter int NUM_IRQ = 8,
  parameter int PC_W    = 16
) (
  // Clock and reset.
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  // Operand reads.
  input  wire logic [4:0]         rd_a_idx_i,
  input  wire logic [4:0]         rd_b_idx_i,
  output logic      [15:0]        rd_a_o,
  output logic      [7:0]         rd_b_o,
  // Result write: byte, or word into an aligned pair.
  input  wire logic               wr_en_i,
  input  wire logic               wr_wide_i,
  input  wire logic [4:0]         wr_idx_i,
  input  wire logic [15:0]        wr_data_i,
  // ALU flag update.
  input  wire logic               alu_upd_i,
  input  wire logic [7:0]         alu_mask_i,
  input  wire logic               alu_h_i,
  input  wire logic               alu_v_i,
  input  wire logic               alu_n_i,
  input  wire logic               alu_z_i,
  input  wire logic               alu_c_i,
  // Bit copy and interrupt enable operations.
  input  wire logic               bit_to_flag_op_i,
  input  wire logic               flag_to_bit_op_i,
  input  wire logic [4:0]         bit_reg_idx_i,
  input  wire logic [2:0]         bit_pos_i,
  input  wire logic               irq_on_op_i,
  input  wire logic               irq_off_op_i,
  input  wire logic               return_from_irq_op_i,
  // Pointer access.
  input  wire logic               ptr_en_i,
  input  wire logic [1:0]         ptr_sel_i,
  input  wire logic [1:0]         ptr_mode_i,
  input  wire logic [5:0]         ptr_disp_i,
  output logic      [15:0]        ptr_addr_o,
  // Data space access (load_op / store_op or direct I/O).
  input  wire logic               ds_en_i,
  input  wire logic               ds_we_i,
  input  wire logic               ds_io_i,
  input  wire logic [15:0]        ds_addr_i,
  input  wire logic [7:0]         ds_wdata_i,
  output logic      [7:0]         ds_rdata_o,
  output logic                    ds_err_o,
  output logic      [15:0]        ext_addr_o,
  output logic                    ext_en_o,
  // Interrupts and calls.
  input  wire logic [NUM_IRQ-1:0] irq_pend_i,
  input  wire logic               call_i,
  input  wire logic [PC_W-1:0]    ret_pc_i,
  output logic                    irq_take_o,
  output logic      [$clog2(NUM_IRQ)-1:0] irq_vec_o,
  output logic                    push_en_o,
  output logic      [PC_W-1:0]    push_pc_o,
  // Fetch.
  input  wire logic               run_i,
  input  wire logic               jump_i,
  input  wire logic [PC_W-1:0]    jump_pc_i,
  input  wire logic               wide_i,
  input  wire logic [15:0]        pm_data_i,
  output logic      [PC_W-1:0]    pm_addr_o,
  output logic      [15:0]        instr_o,
  output logic      [15:0]        instr_ext_o,
  output logic                    instr_valid_o,
  // Status flags.
  output logic      [7:0]         status_flags_o
);

  localparam int VEC_W = $clog2(NUM_IRQ);

  logic [7:0]       regs_reg [crf_pkg::NUM_REGS];
  logic [7:0]       status_flags_reg;
  logic [7:0]       status_flags_next;
  logic [5:0]       io_addr;
  logic [15:0]      ds_eff;
  logic             ds_is_reg;
  logic             ds_is_status;
  logic             status_wr;
  logic [4:0]       ptr_lo;
  logic [15:0]      ptr_val;
  logic [15:0]      ptr_new;
  logic             irq_any;
  logic [VEC_W-1:0] irq_low;

  // Index of the low byte of a word pair.
  function automatic logic [4:0] pair_lo(input logic [4:0] idx);
    return {idx[4:1], 1'b0};
  endfunction

  // Direct I/O addresses map into data space above the register file.
  assign io_addr   = ds_addr_i[5:0];
  assign ds_eff    = ds_io_i ? (16'(io_addr) + crf_pkg::IO_TO_DS)
                             : ds_addr_i;
  assign ds_is_reg = ds_eff <= crf_pkg::DS_REG_LAST;
  assign ds_is_status = ds_eff == crf_pkg::STATUS_DS_OFS;
  assign status_wr = ds_en_i && ds_we_i && ds_is_status;

  // Pointer selection and arithmetic.
  always_comb begin
    unique case (ptr_sel_i)
      2'd0:    ptr_lo = crf_pkg::PTR0_LO;
      2'd1:    ptr_lo = crf_pkg::PTR1_LO;
      default: ptr_lo = crf_pkg::PTR2_LO;
    endcase
  end
  assign ptr_val = {regs_reg[ptr_lo + 5'd1], regs_reg[ptr_lo]};
  always_comb begin
    ptr_new = ptr_val;
    if (ptr_mode_i == crf_pkg::CRF_PTR_POSTI) begin
      ptr_new = ptr_val + 16'h0001;
    end else if (ptr_mode_i == crf_pkg::CRF_PTR_PRED) begin
      ptr_new = ptr_val - 16'h0001;
    end
  end

  // Register file writes; the pointer update cannot collide with a result
  // write because the decoder issues them in different instructions.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < crf_pkg::NUM_REGS; i++) begin
        regs_reg[i] <= 8'h00;
      end
    end else begin
      if (wr_en_i && wr_wide_i) begin
        regs_reg[pair_lo(wr_idx_i)]        <= wr_data_i[7:0];
        regs_reg[pair_lo(wr_idx_i) + 5'd1] <= wr_data_i[15:8];
      end else if (wr_en_i) begin
        regs_reg[wr_idx_i] <= wr_data_i[7:0];
      end
      if (flag_to_bit_op_i) begin
        regs_reg[bit_reg_idx_i][bit_pos_i] <=
          status_flags_reg[crf_pkg::FLAG_T];
      end
      if (ds_en_i && ds_we_i && ds_is_reg) begin
        regs_reg[ds_eff[4:0]] <= ds_wdata_i;
      end
      if (ptr_en_i && ptr_mode_i[1]) begin
        regs_reg[ptr_lo]        <= ptr_new[7:0];
        regs_reg[ptr_lo + 5'd1] <= ptr_new[15:8];
      end
    end
  end

  // Operand reads are registered, so operands appear one edge after the
  // index; write-back lands on the same edge the next operands are taken.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_a_o <= 16'h0000;
      rd_b_o <= 8'h00;
    end else begin
      rd_a_o <= {regs_reg[pair_lo(rd_a_idx_i) + 5'd1],
                 regs_reg[rd_a_idx_i]};
      rd_b_o <= regs_reg[rd_b_idx_i];
    end
  end

  // Status flag next value.
  always_comb begin
    status_flags_next = status_flags_reg;
    if (alu_upd_i) begin
      if (alu_mask_i[crf_pkg::FLAG_H]) begin
        status_flags_next[crf_pkg::FLAG_H] = alu_h_i;
      end
      if (alu_mask_i[crf_pkg::FLAG_V]) begin
        status_flags_next[crf_pkg::FLAG_V] = alu_v_i;
      end
      if (alu_mask_i[crf_pkg::FLAG_N]) begin
        status_flags_next[crf_pkg::FLAG_N] = alu_n_i;
      end
      if (alu_mask_i[crf_pkg::FLAG_Z]) begin
        status_flags_next[crf_pkg::FLAG_Z] = alu_z_i;
      end
      if (alu_mask_i[crf_pkg::FLAG_C]) begin
        status_flags_next[crf_pkg::FLAG_C] = alu_c_i;
      end
      status_flags_next[crf_pkg::FLAG_S] =
        status_flags_next[crf_pkg::FLAG_N] ^
        status_flags_next[crf_pkg::FLAG_V];
    end
    if (bit_to_flag_op_i) begin
      status_flags_next[crf_pkg::FLAG_T] =
        regs_reg[bit_reg_idx_i][bit_pos_i];
    end
    if (irq_on_op_i || return_from_irq_op_i) begin
      status_flags_next[crf_pkg::FLAG_I] = 1'b1;
    end
    if (irq_off_op_i || irq_take_o) begin
      status_flags_next[crf_pkg::FLAG_I] = 1'b0;
    end
    if (status_wr) begin
      status_flags_next = ds_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      status_flags_reg <= crf_pkg::STATUS_RESET;
      status_flags_o   <= crf_pkg::STATUS_RESET;
    end else begin
      status_flags_reg <= status_flags_next;
      status_flags_o   <= status_flags_next;
    end
  end

  // Lowest-numbered pending line wins.
  always_comb begin
    irq_any = 1'b0;
    irq_low = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_pend_i[i]) begin
        irq_any = 1'b1;
        irq_low = VEC_W'(i);
      end
    end
  end

  // Interrupt take and return-address push. The status flags are not
  // stacked: the service routine must save them itself.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_take_o <= 1'b0;
      irq_vec_o  <= '0;
      push_en_o  <= 1'b0;
      push_pc_o  <= '0;
    end else begin
      irq_take_o <= 1'b0;
      push_en_o  <= 1'b0;
      if (irq_any && status_flags_reg[crf_pkg::FLAG_I] && !irq_take_o) begin
        irq_take_o <= 1'b1;
        irq_vec_o  <= irq_low;
      end
      if ((irq_any && status_flags_reg[crf_pkg::FLAG_I] && !irq_take_o)
          || call_i) begin
        push_en_o <= 1'b1;
        push_pc_o <= ret_pc_i;
      end
    end
  end

  // Data space reads and the extended region strobe.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ds_rdata_o <= 8'h00;
      ds_err_o   <= 1'b0;
      ext_addr_o <= 16'h0000;
      ext_en_o   <= 1'b0;
      ptr_addr_o <= 16'h0000;
    end else begin
      ds_err_o <= 1'b0;
      ext_en_o <= 1'b0;
      ptr_addr_o <= (ptr_mode_i == crf_pkg::CRF_PTR_DISP)
                    ? ptr_val + 16'(ptr_disp_i)
                    : ((ptr_mode_i == crf_pkg::CRF_PTR_PRED) ? ptr_new
                                                             : ptr_val);
      if (ds_en_i) begin
        ds_rdata_o <= 8'h00;
        if (ds_is_reg) begin
          ds_rdata_o <= regs_reg[ds_eff[4:0]];
        end else if (ds_is_status) begin
          ds_rdata_o <= status_flags_reg;
        end else if (ds_eff <= crf_pkg::DS_IO_LAST) begin
          ext_en_o   <= 1'b1;
          ext_addr_o <= ds_eff;
        end else if (!ds_io_i && ds_eff <= crf_pkg::DS_EXT_LAST) begin
          ext_en_o   <= 1'b1;
          ext_addr_o <= ds_eff;
        end else begin
          ds_err_o <= 1'b1;
        end
      end
    end
  end

  crf_fetch #(
    .PC_W(PC_W)
  ) u_fetch (
    .clk_sys_i    (clk_sys_i),
    .rst_i        (rst_i),
    .run_i        (run_i),
    .jump_i       (jump_i),
    .jump_pc_i    (jump_pc_i),
    .wide_i       (wide_i),
    .pm_data_i    (pm_data_i),
    .pm_addr_o    (pm_addr_o),
    .instr_o      (instr_o),
    .instr_ext_o  (instr_ext_o),
    .instr_valid_o(instr_valid_o)
  );

  a_status_sign: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    alu_upd_i && !status_wr |=> status_flags_reg[crf_pkg::FLAG_S] ==
      (status_flags_reg[crf_pkg::FLAG_N] ^ status_flags_reg[crf_pkg::FLAG_V]))
    else $error("sign flag is not negative xor overflow");

  a_status_wr_wins: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    status_wr |=> status_flags_reg == $past(ds_wdata_i))
    else $error("status write did not load all flags");

  a_irq_gate_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !status_flags_reg[crf_pkg::FLAG_I] |=> !irq_take_o)
    else $error("interrupt taken with global enable clear");

  a_irq_clears_i: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    irq_take_o && !status_wr |=> !status_flags_reg[crf_pkg::FLAG_I])
    else $error("global enable not cleared on interrupt entry");

  a_return_from_irq_op_sets_i: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    return_from_irq_op_i && !irq_off_op_i && !irq_take_o && !status_wr
      |=> status_flags_reg[crf_pkg::FLAG_I])
    else $error("return did not set global enable");

  a_reg_wr_rd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_en_i && !wr_wide_i && !ds_en_i && !ptr_en_i && !flag_to_bit_op_i
      ##1 rd_b_idx_i == $past(wr_idx_i)
      |=> rd_b_o == $past(wr_data_i[7:0], 2))
    else $error("register read does not return written byte");

  a_irq_push_pc: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    irq_take_o |-> push_en_o)
    else $error("interrupt entry did not push return counter");

  a_irq_lowest: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    irq_any && status_flags_reg[crf_pkg::FLAG_I] && !irq_take_o
      |=> ($past(irq_pend_i) & ~({NUM_IRQ{1'b1}} << irq_vec_o))
          == '0)
    else $error("lowest vector not served first");

  a_io_ext_refused: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ds_en_i && ds_io_i |=> !ds_err_o)
    else $error("direct I/O address fell outside I/O space");

  c_alu_update: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    alu_upd_i ##1 alu_upd_i);
  c_irq_taken: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    irq_take_o);
  c_status_write: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    status_wr && alu_upd_i);
  c_ptr_post_inc: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    ptr_en_i && ptr_mode_i == crf_pkg::CRF_PTR_POSTI);

endmodule
`default_nettype wire

/* crf_pkg.sv */
package crf_pkg;

  // Register file geometry.
  localparam int NUM_REGS  = 32;
  localparam int REG_W     = 8;
  localparam int IDX_W     = 5;

  // Pointer pairs: the lower register of each pair holds the low byte.
  localparam logic [4:0] PTR0_LO = 5'h1a;
  localparam logic [4:0] PTR1_LO = 5'h1c;
  localparam logic [4:0] PTR2_LO = 5'h1e;

  // Data space map.
  localparam logic [15:0] DS_REG_LAST  = 16'h001f;
  localparam logic [15:0] DS_IO_FIRST  = 16'h0020;
  localparam logic [15:0] DS_IO_LAST   = 16'h005f;
  localparam logic [15:0] DS_EXT_FIRST = 16'h0060;
  localparam logic [15:0] DS_EXT_LAST  = 16'h00ff;
  localparam logic [15:0] IO_TO_DS     = 16'h0020;
  localparam logic [5:0]  IO_LAST      = 6'h3f;

  // Status flags register.
  localparam logic [15:0] STATUS_DS_OFS = 16'h005f;
  localparam logic [5:0]  STATUS_IO_OFS = 6'h3f;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;

  // Status flag bit positions.
  localparam int FLAG_I = 7;
  localparam int FLAG_T = 6;
  localparam int FLAG_H = 5;
  localparam int FLAG_S = 4;
  localparam int FLAG_V = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;

  // Pointer addressing modes.
  typedef enum logic [1:0] {
    CRF_PTR_PLAIN = 2'b00,
    CRF_PTR_DISP  = 2'b01,
    CRF_PTR_POSTI = 2'b10,
    CRF_PTR_PRED  = 2'b11
  } crf_ptr_mode_t;

  // Fetch pipeline states.
  typedef enum logic [1:0] {
    CRF_FE_IDLE  = 2'b00,
    CRF_FE_FIRST = 2'b01,
    CRF_FE_RUN   = 2'b10,
    CRF_FE_WIDE  = 2'b11
  } crf_fetch_state_t;

endpackage

/* crf_fetch.sv */
`timescale 1ns/1ps
`default_nettype none
// Single-level prefetch: the next word is fetched while the current executes.
module crf_fetch #(
  parameter int PC_W = 16
) (
  // Clock and reset.
  input  wire logic            clk_sys_i,
  input  wire logic            rst_i,
  // Control from the decoder.
  input  wire logic            run_i,
  input  wire logic            jump_i,
  input  wire logic [PC_W-1:0] jump_pc_i,
  input  wire logic            wide_i,
  // Program memory.
  input  wire logic [15:0]     pm_data_i,
  output logic      [PC_W-1:0] pm_addr_o,
  // Instruction to the decoder.
  output logic      [15:0]     instr_o,
  output logic      [15:0]     instr_ext_o,
  output logic                 instr_valid_o
);

  crf_pkg::crf_fetch_state_t state_reg;
  logic [PC_W-1:0]           pc_reg;

  assign pm_addr_o = pc_reg;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg     <= crf_pkg::CRF_FE_IDLE;
      pc_reg        <= '0;
      instr_o       <= 16'h0000;
      instr_ext_o   <= 16'h0000;
      instr_valid_o <= 1'b0;
    end else begin
      instr_valid_o <= 1'b0;
      unique case (state_reg)
        crf_pkg::CRF_FE_IDLE: begin
          if (run_i) begin
            state_reg <= crf_pkg::CRF_FE_FIRST;
          end
        end
        crf_pkg::CRF_FE_FIRST: begin
          // Pipeline fill: first word arrives, no instruction yet.
          instr_o   <= pm_data_i;
          pc_reg    <= pc_reg + PC_W'(1);
          state_reg <= crf_pkg::CRF_FE_RUN;
        end
        crf_pkg::CRF_FE_RUN: begin
          instr_valid_o <= 1'b1;
          if (jump_i) begin
            // A jump discards the prefetched word and refills.
            pc_reg        <= jump_pc_i;
            instr_valid_o <= 1'b0;
            state_reg     <= crf_pkg::CRF_FE_FIRST;
          end else if (wide_i) begin
            instr_ext_o <= pm_data_i;
            pc_reg      <= pc_reg + PC_W'(1);
            state_reg   <= crf_pkg::CRF_FE_WIDE;
          end else begin
            instr_o <= pm_data_i;
            pc_reg  <= pc_reg + PC_W'(1);
          end
        end
        crf_pkg::CRF_FE_WIDE: begin
          // Second word of a 32-bit instruction consumed one extra cycle.
          instr_o   <= pm_data_i;
          pc_reg    <= pc_reg + PC_W'(1);
          state_reg <= crf_pkg::CRF_FE_RUN;
        end
      endcase
    end
  end

  a_fetch_one_per: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == crf_pkg::CRF_FE_RUN && !jump_i && !wide_i)
      |=> pc_reg == $past(pc_reg) + PC_W'(1))
    else $error("fetch did not advance by one word");

  a_fetch_wide_two: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == crf_pkg::CRF_FE_RUN && !jump_i && wide_i)
      |=> state_reg == crf_pkg::CRF_FE_WIDE ##1
          state_reg == crf_pkg::CRF_FE_RUN)
    else $error("wide instruction not fetched over two words");

endmodule
`default_nettype wire

/* crf_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// Program memory behind the fetch stage. Each word holds its low address byte under its complement,
// so a fetched word can be recognised without a lookup table.
module crf_prog_mem (
  // Fetch side.
  input  wire logic [15:0] pm_addr_i,
  output logic      [15:0] pm_data_o
);
  assign pm_data_o = {~pm_addr_i[7:0], pm_addr_i[7:0]};
endmodule
`default_nettype wire

/* core_register_file_status_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); \
  end \
end
module core_register_file_status_test;
  logic        clk_sys_i, rst_i;
  logic [4:0]  rd_a_idx_i, rd_b_idx_i, wr_idx_i, bit_reg_idx_i;
  logic [15:0] rd_a_o, wr_data_i, ptr_addr_o, ds_addr_i, ext_addr_o;
  logic [7:0]  rd_b_o, alu_mask_i, ds_wdata_i, ds_rdata_o, irq_pend_i;
  logic        wr_en_i, wr_wide_i, alu_upd_i, alu_h_i, alu_v_i, alu_n_i;
  logic        alu_z_i, alu_c_i, bit_to_flag_op_i, flag_to_bit_op_i;
  logic [2:0]  bit_pos_i, irq_vec_o;
  logic        irq_on_op_i, irq_off_op_i, return_from_irq_op_i, ptr_en_i;
  logic [1:0]  ptr_sel_i, ptr_mode_i;
  logic [5:0]  ptr_disp_i;
  logic        ds_en_i, ds_we_i, ds_io_i, ds_err_o, ext_en_o, call_i;
  logic [15:0] ret_pc_i, push_pc_o, pm_addr_o, pm_data_i, instr_o;
  logic [15:0] instr_ext_o, prev_pc, jump_pc_i;
  logic        irq_take_o, push_en_o, run_i, instr_valid_o, jump_i, wide_i;
  logic [7:0]  status_flags_o;
  int          n_fail, tests_run;

  crf_core_regs i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .rd_a_idx_i(rd_a_idx_i), .rd_b_idx_i(rd_b_idx_i), .rd_a_o(rd_a_o),
    .rd_b_o(rd_b_o), .wr_en_i(wr_en_i), .wr_wide_i(wr_wide_i),
    .wr_idx_i(wr_idx_i), .wr_data_i(wr_data_i), .alu_upd_i(alu_upd_i),
    .alu_mask_i(alu_mask_i), .alu_h_i(alu_h_i), .alu_v_i(alu_v_i),
    .alu_n_i(alu_n_i), .alu_z_i(alu_z_i), .alu_c_i(alu_c_i),
    .bit_to_flag_op_i(bit_to_flag_op_i), .flag_to_bit_op_i(flag_to_bit_op_i),
    .bit_reg_idx_i(bit_reg_idx_i), .bit_pos_i(bit_pos_i),
    .irq_on_op_i(irq_on_op_i), .irq_off_op_i(irq_off_op_i),
    .return_from_irq_op_i(return_from_irq_op_i), .ptr_en_i(ptr_en_i),
    .ptr_sel_i(ptr_sel_i), .ptr_mode_i(ptr_mode_i), .ptr_disp_i(ptr_disp_i),
    .ptr_addr_o(ptr_addr_o), .ds_en_i(ds_en_i), .ds_we_i(ds_we_i),
    .ds_io_i(ds_io_i), .ds_addr_i(ds_addr_i), .ds_wdata_i(ds_wdata_i),
    .ds_rdata_o(ds_rdata_o), .ds_err_o(ds_err_o), .ext_addr_o(ext_addr_o),
    .ext_en_o(ext_en_o), .irq_pend_i(irq_pend_i), .call_i(call_i),
    .ret_pc_i(ret_pc_i), .irq_take_o(irq_take_o), .irq_vec_o(irq_vec_o),
    .push_en_o(push_en_o), .push_pc_o(push_pc_o), .run_i(run_i),
    .jump_i(jump_i), .jump_pc_i(jump_pc_i), .wide_i(wide_i),
    .pm_data_i(pm_data_i), .pm_addr_o(pm_addr_o), .instr_o(instr_o),
    .instr_ext_o(instr_ext_o), .instr_valid_o(instr_valid_o),
    .status_flags_o(status_flags_o));

  crf_prog_mem i_pmem (.pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i));

  always #12.5 clk_sys_i = ~clk_sys_i;

  task tick;
    @(posedge clk_sys_i);
  endtask

  task test_done;
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task ds(input logic io, we, alu, input logic [15:0] a,
          input logic [7:0] d);
    tick; ds_en_i <= 1'b1; ds_io_i <= io; ds_we_i <= we;
    ds_addr_i <= a; ds_wdata_i <= d; alu_upd_i <= alu;
    tick; ds_en_i <= 1'b0; ds_we_i <= 1'b0; alu_upd_i <= 1'b0;
    #1;
  endtask

  task alu(input logic [4:0] hvnzc, input logic [7:0] e);
    tick; alu_upd_i <= 1'b1; alu_mask_i <= 8'h2f;
    {alu_h_i, alu_v_i, alu_n_i, alu_z_i, alu_c_i} <= hvnzc;
    tick; alu_upd_i <= 1'b0;
    #1 `CHK(status_flags_o, e)
  endtask

  task ptr(input logic [1:0] m, input logic [5:0] d, input logic [15:0] e);
    tick; ptr_en_i <= 1'b1; ptr_mode_i <= m; ptr_disp_i <= d;
    tick; ptr_en_i <= 1'b0;
    #1 `CHK(ptr_addr_o, e)
  endtask

  task t_regs;
    tick; wr_en_i <= 1'b1; wr_idx_i <= 5'h05; wr_data_i <= 16'h0012;
    tick; wr_wide_i <= 1'b1; wr_idx_i <= 5'h1a; wr_data_i <= 16'h1234;
    rd_b_idx_i <= 5'h05;
    tick; wr_en_i <= 1'b0; wr_wide_i <= 1'b0; rd_a_idx_i <= 5'h1a;
    #1 `CHK(rd_b_o, 8'h12)
    tick; #1 `CHK(rd_a_o, 16'h1234)
  endtask

  task t_space;
    ds(1'b0, 1'b0, 1'b0, 16'h0005, 8'h00);
    `CHK(ds_rdata_o, 8'h12)
    ds(1'b0, 1'b1, 1'b1, 16'h005f, 8'ha5);
    `CHK(status_flags_o, 8'ha5)
    ds(1'b1, 1'b0, 1'b0, 16'h003f, 8'h00);
    `CHK(ds_rdata_o, 8'ha5)
    ds(1'b1, 1'b0, 1'b0, 16'h0005, 8'h00);
    `CHK({ext_en_o, ext_addr_o}, {1'b1, 16'h0025})
    ds(1'b0, 1'b0, 1'b0, 16'h0080, 8'h00);
    `CHK({ext_en_o, ds_err_o, ext_addr_o}, {2'b10, 16'h0080})
    ds(1'b1, 1'b1, 1'b0, 16'h003f, 8'h00);
    `CHK(status_flags_o, 8'h00)
  endtask

  task t_bits;
    alu(5'b10101, 8'h35);
    alu(5'b01110, 8'h0e);
    tick; bit_to_flag_op_i <= 1'b1; bit_reg_idx_i <= 5'h05;
    bit_pos_i <= 3'd4;
    tick; bit_to_flag_op_i <= 1'b0; flag_to_bit_op_i <= 1'b1;
    bit_reg_idx_i <= 5'h06; bit_pos_i <= 3'd0;
    #1 `CHK(status_flags_o, 8'h4e)
    tick; flag_to_bit_op_i <= 1'b0; rd_b_idx_i <= 5'h06;
    tick; #1 `CHK(rd_b_o, 8'h01)
  endtask

  task t_irq;
    tick; irq_on_op_i <= 1'b1;
    tick; irq_on_op_i <= 1'b0; irq_pend_i <= 8'h28; ret_pc_i <= 16'h0123;
    #1 `CHK(status_flags_o[7], 1'b1)
    tick; #1 `CHK({irq_take_o, push_en_o, irq_vec_o}, 5'b11011)
    `CHK(push_pc_o, 16'h0123)
    tick; #1 `CHK({status_flags_o[7], irq_take_o}, 2'b00)
    repeat (3) tick;
    #1 `CHK(irq_take_o, 1'b0)
    tick; irq_pend_i <= 8'h00; call_i <= 1'b1; ret_pc_i <= 16'hbeef;
    tick; call_i <= 1'b0; return_from_irq_op_i <= 1'b1;
    #1 `CHK({push_en_o, push_pc_o}, {1'b1, 16'hbeef})
    tick; return_from_irq_op_i <= 1'b0; irq_off_op_i <= 1'b1;
    #1 `CHK(status_flags_o[7], 1'b1)
    tick; irq_off_op_i <= 1'b0;
    #1 `CHK(status_flags_o[7], 1'b0)
  endtask

  task t_ptr_fetch;
    ptr(2'd2, 6'h00, 16'h1234);
    ptr(2'd3, 6'h00, 16'h1234);
    ptr(2'd1, 6'h05, 16'h1239);
    ptr(2'd0, 6'h00, 16'h1234);
    tick; run_i <= 1'b1;
    repeat (4) tick;
    #1 prev_pc = pm_addr_o;
    tick; #1 `CHK(pm_addr_o, prev_pc + 16'h0001)
    `CHK({instr_valid_o, instr_o}, {1'b1, ~prev_pc[7:0], prev_pc[7:0]})
    tick; wide_i <= 1'b1;
    tick; wide_i <= 1'b0;
    tick; #1 `CHK({instr_valid_o, instr_ext_o, instr_o}, {1'b0, 32'hfa05f906})
    tick; jump_i <= 1'b1; jump_pc_i <= 16'h0040;
    tick; jump_i <= 1'b0;
    tick; #1 `CHK({pm_addr_o, instr_o}, {16'h0041, 16'hbf40})
  endtask

  initial begin
    {clk_sys_i, wr_en_i, wr_wide_i, alu_upd_i, ds_en_i, ds_we_i} = '0;
    {ds_io_i, call_i, run_i, ptr_en_i, bit_to_flag_op_i, jump_i, wide_i} = '0;
    {flag_to_bit_op_i, irq_on_op_i, irq_off_op_i} = '0;
    {return_from_irq_op_i, alu_h_i, alu_v_i, alu_n_i, alu_z_i} = '0;
    {rd_a_idx_i, rd_b_idx_i, wr_idx_i, bit_reg_idx_i, bit_pos_i} = '0;
    {wr_data_i, alu_mask_i, ptr_sel_i, ptr_mode_i, ptr_disp_i} = '0;
    {ds_addr_i, ds_wdata_i, irq_pend_i, ret_pc_i, alu_c_i, jump_pc_i} = '0;
    n_fail = 0;
    tests_run = 0;
    rst_i = 1'b1;
    repeat (5) tick;
    rst_i <= 1'b0;
    #1 `CHK(status_flags_o, 8'h00)
    t_regs;
    t_space;
    t_bits;
    t_irq;
    t_ptr_fetch;
    test_done;
  end

  // The whole sequence needs about sixty cycles.
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    n_fail++;
    test_done;
  end
endmodule
`default_nettype wire
